// ==== verilog/hsqc_pkg.sv ====
package hsqc_pkg;

    // ==========================================================
    // Clock and time bases
    localparam int CLK_HZ     = 20_000_000;
    localparam int CLK_MHZ    = CLK_HZ / 1_000_000;
    localparam int US_PER_MS  = 1000;
    localparam int TB0_NS     = 250;
    localparam int TB1_NS     = 1000;
    localparam int TB2_NS     = 10000;
    localparam int TB3_NS     = 100000;
    localparam int TB0_CYC    = TB0_NS * CLK_MHZ / 1000;
    localparam int TB1_CYC    = TB1_NS * CLK_MHZ / 1000;
    localparam int TB2_CYC    = TB2_NS * CLK_MHZ / 1000;
    localparam int TB3_CYC    = TB3_NS * CLK_MHZ / 1000;
    localparam int CYC_PER_US = CLK_MHZ;

    // ==========================================================
    // Reset values and widths
    localparam int             N_CMP      = 16;
    localparam int             FCNT_W     = 18;
    localparam logic [31:0]    UPPER_RST  = 32'h7FFF_FFFF;
    localparam logic [31:0]    LOWER_RST  = 32'h8000_0000;
    localparam logic [31:0]    PRESET_RST = 32'h0000_0000;

    // ==========================================================
    // Modes
    typedef enum logic [2:0] {
        HSQC_M_2P1 = 3'h0, HSQC_M_2P2 = 3'h1, HSQC_M_2P4 = 3'h2, HSQC_M_IN1 = 3'h3,
        HSQC_M_IN2 = 3'h4, HSQC_M_DR1 = 3'h5, HSQC_M_DR2 = 3'h6
    } hsqc_method_t;

    typedef enum logic [1:0] {
        HSQC_T_LO = 2'h0, HSQC_T_HI = 2'h1, HSQC_T_TGT = 2'h2
    } hsqc_tbl_t;

    // ==========================================================
    // Per-counter configuration
    typedef struct packed {
        logic [2:0]    src;
        hsqc_method_t  method;
        logic          ring;
        logic          ovf_en;
        logic          dir_rev;
        logic [3:0]    z_func;
        logic [2:0]    ctl0_func;
        logic [1:0]    ctl1_func;
        logic [2:0]    ab_filt;
        logic [2:0]    z_filt;
        logic [3:0]    ctl_filt;
        logic [31:0]   upper;
        logic [31:0]   lower;
        logic [31:0]   preset;
        logic          samp_mode;
        logic [15:0]   samp_us;
        logic          cmp_target;
        logic [15:0]   cmp_en;
        logic [15:0]   band_act;
        logic [15:0]   up_act;
        logic [15:0]   dn_act;
        logic [1:0]    ext_en;
        logic [3:0]    ext_sel0;
        logic [3:0]    ext_sel1;
        logic [9:0]    hold_ms;
    } hsqc_cfg_t;

    typedef struct packed {
        logic          we;
        logic          ch;
        hsqc_tbl_t     kind;
        logic [3:0]    idx;
        logic [31:0]   data;
    } hsqc_tbl_wr_t;

    // Input time constants of phase inputs, rounded up to whole cycles.
    function automatic logic [FCNT_W-1:0] ab_filt_cyc(input logic [2:0] sel);
        case (sel)
            3'h1:    ab_filt_cyc = 18'h00002;
            3'h2:    ab_filt_cyc = 18'h00004;
            3'h3:    ab_filt_cyc = 18'h0000A;
            3'h4:    ab_filt_cyc = 18'h00014;
            3'h5:    ab_filt_cyc = 18'h00028;
            3'h6:    ab_filt_cyc = 18'h000C8;
            default: ab_filt_cyc = 18'h00000;
        endcase
    endfunction

    // Control input time constants in microseconds.
    function automatic logic [13:0] ctl_filt_us(input logic [3:0] sel);
        case (sel)
            4'h1:    ctl_filt_us = 14'h0002;
            4'h2:    ctl_filt_us = 14'h0005;
            4'h3:    ctl_filt_us = 14'h000A;
            4'h4:    ctl_filt_us = 14'h0014;
            4'h5:    ctl_filt_us = 14'h0032;
            4'h6:    ctl_filt_us = 14'h0064;
            4'h7:    ctl_filt_us = 14'h01F4;
            4'h8:    ctl_filt_us = 14'h03E8;
            4'h9:    ctl_filt_us = 14'h07D0;
            4'hA:    ctl_filt_us = 14'h1388;
            4'hB:    ctl_filt_us = 14'h2710;
            default: ctl_filt_us = 14'h0000;
        endcase
    endfunction

endpackage

// ==== verilog/hsqc_top.sv ====
// ==========================================================
// One counter channel.
module hsqc_chan
    import hsqc_pkg::*;
#(
    parameter int CYC_US = CYC_PER_US
) (
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    input  wire logic                 us_tick,
    input  wire logic                 ms_tick,
    input  wire hsqc_cfg_t            cfg,
    input  wire hsqc_tbl_wr_t         tbl,
    input  wire logic                 my_ch,
    input  wire logic                 sw_en,
    input  wire logic                 sw_reset,
    input  wire logic                 sw_preset,
    input  wire logic                 flag_clr,
    input  wire logic [5:0]           pins,
    output logic signed [31:0]        count,
    output logic signed [31:0]        cap_val,
    output logic                      cap_evt,
    output logic [N_CMP-1:0]          flags,
    output logic [1:0]                ext_out,
    output logic                      ovf,
    output logic                      unf
);

    typedef struct packed {
        logic [5:0]                   sy1;
        logic [5:0]                   sy2;
        logic [5:0]                   filt;
        logic [5:0]                   prv;
        logic [5:0][FCNT_W-1:0]       fcnt;
        logic [11:0]                  tb_cnt;
        logic [15:0]                  samp_cnt;
        logic [1:0][9:0]              hold;
        logic signed [31:0]           count;
        logic signed [31:0]           cap;
        logic                         cap_evt;
        logic                         ovf;
        logic                         unf;
        logic [N_CMP-1:0]             flag;
        logic [1:0]                   ext;
        logic [N_CMP-1:0][31:0]       lo;
        logic [N_CMP-1:0][31:0]       hi;
        logic [N_CMP-1:0][31:0]       tgt;
    } hsqc_chan_st_t;

    hsqc_chan_st_t      st_reg;
    hsqc_chan_st_t      st_next;
    logic [5:0]         rise;
    logic [5:0]         fall;
    logic               step;
    logic               up;
    logic               en;
    logic               do_rst;
    logic               do_pre;
    logic               cap_go;
    logic               ctl0_lvl;
    logic               z_lvl;
    logic [11:0]        tb_lim;
    logic [FCNT_W-1:0]  lim;
    logic [31:0]        ctl_cyc;
    logic signed [31:0] nx;
    logic [3:0]         sel;
    logic               ovf_set;
    logic               unf_set;

    assign count   = st_reg.count;
    assign cap_val = st_reg.cap;
    assign cap_evt = st_reg.cap_evt;
    assign flags   = st_reg.flag;
    assign ext_out = st_reg.ext;
    assign ovf     = st_reg.ovf;
    assign unf     = st_reg.unf;

    always_comb begin
        st_next = st_reg;
        // Pins are A, B, Z, control 0, control 1, capture.
        st_next.sy1 = pins;
        st_next.sy2 = st_reg.sy1;
        ctl_cyc = 32'(ctl_filt_us(cfg.ctl_filt)) * 32'(CYC_US);
        for (int i = 0; i < 6; i++) begin
            if (i < 2) lim = ab_filt_cyc(cfg.ab_filt);
            else if (i == 2) lim = ab_filt_cyc(cfg.z_filt);
            else lim = ctl_cyc[FCNT_W-1:0];
            if (st_reg.sy2[i] == st_reg.filt[i]) begin
                st_next.fcnt[i] = '0;
            end else if (st_reg.fcnt[i] >= lim) begin
                st_next.filt[i] = st_reg.sy2[i];
                st_next.fcnt[i] = '0;
            end else begin
                st_next.fcnt[i] = st_reg.fcnt[i] + 18'h00001;
            end
        end
        st_next.prv = st_reg.filt;
        rise = st_reg.filt & ~st_reg.prv;
        fall = ~st_reg.filt & st_reg.prv;
        // Only one step per clock: a fourfold rate near the clock rate can drop edges.
        step = 1'b0;
        up   = 1'b1;
        case (cfg.method)
            HSQC_M_2P1: begin
                step = rise[0];
                up   = ~st_reg.filt[1];
            end
            HSQC_M_2P2: begin
                step = rise[0] | fall[0];
                up   = st_reg.filt[0] ^ st_reg.filt[1];
            end
            HSQC_M_2P4: begin
                step = (rise[0] | fall[0]) ^ (rise[1] | fall[1]);
                up   = (rise[0] | fall[0]) ? (st_reg.filt[0] ^ st_reg.filt[1])
                                           : ~(st_reg.filt[0] ^ st_reg.filt[1]);
            end
            HSQC_M_IN1: begin
                step = rise[0] ^ rise[1];
                up   = rise[0];
            end
            HSQC_M_IN2: begin
                step = (rise[0] | fall[0]) ^ (rise[1] | fall[1]);
                up   = rise[0] | fall[0];
            end
            HSQC_M_DR1: begin
                step = rise[0];
                up   = ~st_reg.filt[1];
            end
            HSQC_M_DR2: begin
                step = rise[0] | fall[0];
                up   = ~st_reg.filt[1];
            end
            default: begin
                step = 1'b0;
                up   = 1'b1;
            end
        endcase
        case (cfg.src)
            3'h1:    tb_lim = 12'(TB0_CYC - 1);
            3'h2:    tb_lim = 12'(TB1_CYC - 1);
            3'h3:    tb_lim = 12'(TB2_CYC - 1);
            default: tb_lim = 12'(TB3_CYC - 1);
        endcase
        if (cfg.src != 3'h0) begin
            up   = 1'b1;
            step = (st_reg.tb_cnt == tb_lim);
            st_next.tb_cnt = step ? 12'h000 : st_reg.tb_cnt + 12'h001;
        end else begin
            st_next.tb_cnt = 12'h000;
        end
        up = up ^ cfg.dir_rev;
        // Enable and reset/preset sources from software, control inputs and zero phase.
        ctl0_lvl = st_reg.filt[3] ^ ~cfg.ctl0_func[0];
        en = sw_en;
        if (cfg.ctl0_func != 3'h0) en = en & ctl0_lvl;
        if (cfg.ctl1_func == 2'h1) en = en & st_reg.filt[4];
        if (cfg.ctl1_func == 2'h2) en = en & ~st_reg.filt[4];
        do_rst = sw_reset;
        do_pre = sw_preset & ~sw_reset;
        case (cfg.ctl0_func)
            3'h3: do_rst = do_rst | rise[3];
            3'h4: do_rst = do_rst | fall[3];
            3'h5: do_pre = do_pre | rise[3];
            3'h6: do_pre = do_pre | fall[3];
            default: ;
        endcase
        z_lvl = 1'b0;
        case (cfg.z_func)
            4'h1: z_lvl = rise[2];
            4'h2: z_lvl = fall[2];
            4'h3: z_lvl = st_reg.filt[2];
            4'h4: z_lvl = ~st_reg.filt[2];
            4'h5: z_lvl = rise[2];
            4'h6: z_lvl = fall[2];
            4'h7: z_lvl = st_reg.filt[2];
            4'h8: z_lvl = ~st_reg.filt[2];
            default: z_lvl = 1'b0;
        endcase
        if (cfg.z_func >= 4'h5) do_pre = do_pre | (z_lvl & ~do_rst);
        else do_rst = do_rst | z_lvl;
        // Count update, clamped or wrapped at the programmed limits.
        ovf_set = 1'b0;
        unf_set = 1'b0;
        nx = st_reg.count;
        if (do_rst) begin
            nx = '0;
        end else if (do_pre) begin
            nx = cfg.preset;
        end else if (step && en) begin
            if (up) begin
                if (st_reg.count >= $signed(cfg.upper)) begin
                    if (cfg.ring) nx = cfg.lower;
                    else if (cfg.ovf_en) ovf_set = 1'b1;
                end else begin
                    nx = st_reg.count + 32'sd1;
                end
            end else begin
                if (st_reg.count <= $signed(cfg.lower)) begin
                    if (cfg.ring) nx = cfg.upper;
                    else if (cfg.ovf_en) unf_set = 1'b1;
                end else begin
                    nx = st_reg.count - 32'sd1;
                end
            end
        end
        // A new over or under flow wins over a clear in the same cycle.
        if (ovf_set) st_next.ovf = 1'b1;
        else if (flag_clr) st_next.ovf = 1'b0;
        if (unf_set) st_next.unf = 1'b1;
        else if (flag_clr) st_next.unf = 1'b0;
        st_next.count = nx;
        // Comparison tables.
        if (tbl.we && tbl.ch == my_ch) begin
            case (tbl.kind)
                HSQC_T_LO:  st_next.lo[tbl.idx]  = tbl.data;
                HSQC_T_HI:  st_next.hi[tbl.idx]  = tbl.data;
                HSQC_T_TGT: st_next.tgt[tbl.idx] = tbl.data;
                default: ;
            endcase
        end
        for (int k = 0; k < N_CMP; k++) begin
            if (!cfg.cmp_en[k]) begin
                st_next.flag[k] = 1'b0;
            end else if (!cfg.cmp_target) begin
                st_next.flag[k] = (st_reg.count >= $signed(st_reg.lo[k]) &&
                                   st_reg.count <= $signed(st_reg.hi[k])) ? cfg.band_act[k]
                                                                          : ~cfg.band_act[k];
            end else if (nx != st_reg.count && nx == $signed(st_reg.tgt[k])) begin
                st_next.flag[k] = up ? cfg.up_act[k] : cfg.dn_act[k];
            end
        end
        // External outputs follow their flags; band mode stretches the on state.
        for (int j = 0; j < 2; j++) begin
            sel = (j == 0) ? cfg.ext_sel0 : cfg.ext_sel1;
            if (!cfg.cmp_target && st_next.flag[sel] && !st_reg.flag[sel]) begin
                st_next.hold[j] = cfg.hold_ms;
            end else if (ms_tick && st_reg.hold[j] != 10'h000) begin
                st_next.hold[j] = st_reg.hold[j] - 10'h001;
            end
            if (cfg.cmp_target) st_next.hold[j] = 10'h000;
            st_next.ext[j] = cfg.ext_en[j] &
                             (st_next.flag[sel] | (st_next.hold[j] != 10'h000));
        end
        // Capture on both edges, or periodically while the capture input is high.
        cap_go = 1'b0;
        if (!cfg.samp_mode) begin
            cap_go = rise[5] | fall[5];
            st_next.samp_cnt = 16'h0000;
        end else if (!st_reg.filt[5]) begin
            st_next.samp_cnt = 16'h0000;
        end else if (us_tick) begin
            if (st_reg.samp_cnt + 16'h0001 >= cfg.samp_us) begin
                cap_go = 1'b1;
                st_next.samp_cnt = 16'h0000;
            end else begin
                st_next.samp_cnt = st_reg.samp_cnt + 16'h0001;
            end
        end
        st_next.cap_evt = cap_go;
        if (cap_go) st_next.cap = st_reg.count;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg       <= '0;
            st_reg.count <= PRESET_RST;
            st_reg.hi    <= {N_CMP{UPPER_RST}};
            st_reg.lo    <= {N_CMP{LOWER_RST}};
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

// ==========================================================
module hsqc_top
    import hsqc_pkg::*;
#(
    parameter int CYC_US = CYC_PER_US
) (
    input  wire logic                   ref_clk,
    input  wire logic                   nrst,
    input  wire hsqc_cfg_t [1:0]        cfg,
    input  wire hsqc_tbl_wr_t           tbl,
    input  wire logic [1:0]             sw_en,
    input  wire logic [1:0]             sw_reset,
    input  wire logic [1:0]             sw_preset,
    input  wire logic [1:0]             flag_clr,
    input  wire logic [1:0][5:0]        pins,
    output logic signed [1:0][31:0]     count,
    output logic signed [1:0][31:0]     cap_val,
    output logic [1:0]                  cap_evt,
    output logic [1:0][N_CMP-1:0]       flags,
    output logic [1:0][1:0]             ext_out,
    output logic [1:0]                  ovf,
    output logic [1:0]                  unf
);

    typedef struct packed {
        logic [15:0] us_div;
        logic [9:0]  ms_div;
        logic        us_tick;
        logic        ms_tick;
    } hsqc_top_st_t;

    hsqc_top_st_t st_reg;
    hsqc_top_st_t st_next;

    // ==========================================================
    // Microsecond and millisecond enables shared by both counters.
    always_comb begin
        st_next = st_reg;
        st_next.us_tick = (st_reg.us_div == 16'(CYC_US - 1));
        st_next.us_div  = st_next.us_tick ? 16'h0000 : st_reg.us_div + 16'h0001;
        st_next.ms_tick = 1'b0;
        if (st_reg.us_tick) begin
            st_next.ms_tick = (st_reg.ms_div == 10'(US_PER_MS - 1));
            st_next.ms_div  = st_next.ms_tick ? 10'h000 : st_reg.ms_div + 10'h001;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Two independent channels.
    for (genvar c = 0; c < 2; c++) begin : g_ch
        hsqc_chan #(.CYC_US(CYC_US)) u_ch (
            .ref_clk   (ref_clk),
            .nrst      (nrst),
            .us_tick   (st_reg.us_tick),
            .ms_tick   (st_reg.ms_tick),
            .cfg       (cfg[c]),
            .tbl       (tbl),
            .my_ch     (1'(c)),
            .sw_en     (sw_en[c]),
            .sw_reset  (sw_reset[c]),
            .sw_preset (sw_preset[c]),
            .flag_clr  (flag_clr[c]),
            .pins      (pins[c]),
            .count     (count[c]),
            .cap_val   (cap_val[c]),
            .cap_evt   (cap_evt[c]),
            .flags     (flags[c]),
            .ext_out   (ext_out[c]),
            .ovf       (ovf[c]),
            .unf       (unf[c])
        );
    end

endmodule

// ==== testbench/hsqc_enc.sv ====
// ==========================================================
// Quadrature encoder model for one shared A/B pair.
module hsqc_enc (
    input  wire logic ref_clk,
    output logic      ph_a,
    output logic      ph_b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] q = 2'h0;
    // Gray order keeps A and B from moving together, as a real encoder does.
    assign ph_a = q[0] ^ q[1];
    assign ph_b = q[1];
    // Five clocks per edge keeps the edge rate at 4 MHz, the top of the range.
    task automatic step(input logic up, input int n);
        repeat (4 * n) begin
            repeat (5) @(posedge ref_clk);
            #5;
            q = up ? q + 2'h1 : q - 2'h1;
        end
    endtask
endmodule

// ==== testbench/hsqc_top_sva.sv ====
// ==========================================================
// Port checker.
module hsqc_sva
    import hsqc_pkg::*;
#(
    parameter int CYC_US = CYC_PER_US
) (
    input  wire logic                   ref_clk,
    input  wire logic                   nrst,
    input  wire hsqc_cfg_t [1:0]        cfg,
    input  wire logic [1:0]             sw_en,
    input  wire logic [1:0]             sw_reset,
    input  wire logic [1:0]             sw_preset,
    input  wire logic [1:0]             flag_clr,
    input  wire logic signed [1:0][31:0] count,
    input  wire logic signed [1:0][31:0] cap_val,
    input  wire logic [1:0]             cap_evt,
    input  wire logic [1:0][N_CMP-1:0]  flags,
    input  wire logic [1:0]             ovf
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    wire logic q0 = cfg[0].z_func == 4'h0 && cfg[0].ctl0_func == 3'h0;
    wire logic q1 = cfg[1].z_func == 4'h0 && cfg[1].ctl0_func == 3'h0;
    // ==========================================================
    // Properties
    property p_rst; sw_reset[0] |=> count[0] == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset did not clear count");
    property p_pre; sw_preset[0] && !sw_reset[0] && q0 |=> count[0] == $past(cfg[0].preset);
    endproperty
    a_pre: assert property (p_pre) else $error("preset value not loaded");
    property p_hold; (!sw_en[1] && !sw_reset[1] && !sw_preset[1] && q1) [*3] |=> $stable(count[1]);
    endproperty
    a_hold: assert property (p_hold) else $error("disabled counter moved");
    sequence s_free; q0 && $stable(cfg[0]) && !$past(sw_reset[0]) && !$past(sw_preset[0]); endsequence
    // Any bigger jump means two edges were merged into one clock.
    property p_step; (s_free and !cfg[0].ring) |-> count[0] - $past(count[0]) + 32'h1 <= 32'h2;
    endproperty
    a_step: assert property (p_step) else $error("count jumped by more than one");
    property p_lin; (s_free and (!cfg[0].ring && $past(count[0]) == cfg[0].upper))
        |-> $signed(count[0]) <= $signed(cfg[0].upper); endproperty
    a_lin: assert property (p_lin) else $error("linear count passed upper limit");
    property p_ovf; ovf[0] && !flag_clr[0] |=> ovf[0]; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag dropped");
    property p_cap; cap_evt[0] |-> cap_val[0] == $past(count[0]); endproperty
    a_cap: assert property (p_cap) else $error("capture value wrong");
    property p_ring; (s_free and (cfg[0].ring && $past(count[0]) == cfg[0].upper
        && count[0] != cfg[0].upper)) |-> count[0] == cfg[0].lower
        || count[0] == cfg[0].upper - 32'h1; endproperty
    a_ring: assert property (p_ring) else $error("ring did not wrap to lower");
    property p_flg; (cfg[0].cmp_en == 16'h0) [*2] |-> flags[0] == 16'h0; endproperty
    a_flg: assert property (p_flg) else $error("disabled flag set");
    c_cap: cover property (cap_evt[0]);
    c_ovf: cover property ($rose(ovf[0]));
    c_flg: cover property ($rose(flags[0][0]));
endmodule

bind hsqc_top hsqc_sva #(.CYC_US(CYC_US)) u_sva (.ref_clk(ref_clk), .nrst(nrst), .cfg(cfg),
    .sw_en(sw_en), .sw_reset(sw_reset), .sw_preset(sw_preset), .flag_clr(flag_clr),
    .count(count), .cap_val(cap_val), .cap_evt(cap_evt), .flags(flags), .ovf(ovf));

// ==== testbench/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import hsqc_pkg::*;
    logic                    ref_clk = 1'b0;
    logic                    nrst = 1'b0;
    hsqc_cfg_t [1:0]         cfg;
    logic [1:0]              sw_en = 2'h0, sw_reset = 2'h0, sw_preset = 2'h0, flag_clr = 2'h0;
    logic                    cap_in = 1'b0;
    logic                    ph_a, ph_b;
    logic signed [1:0][31:0] count, cap_val;
    logic [1:0]              cap_evt, ovf, unf;
    logic [1:0][1:0]         ext_out;
    hsqc_tbl_wr_t            tbl = '0;
    logic [1:0][N_CMP-1:0]   flags;
    int                      mismatches = 0, n_tests = 0, cyc = 0;
    hsqc_method_t            ms[2] = '{HSQC_M_2P1, HSQC_M_DR1};
    // Counter 1 sees the same encoder but stays disabled, so any count there is a leak.
    wire logic [1:0][5:0]    pins = {{4'h0, ph_b, ph_a}, {cap_in, 3'h0, ph_b, ph_a}};

    hsqc_enc u_enc (.ref_clk(ref_clk), .ph_a(ph_a), .ph_b(ph_b));
    hsqc_top #(.CYC_US(2)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .cfg(cfg), .tbl(tbl),
        .sw_en(sw_en), .sw_reset(sw_reset), .sw_preset(sw_preset), .flag_clr(flag_clr),
        .pins(pins), .count(count), .cap_val(cap_val), .cap_evt(cap_evt), .flags(flags),
        .ext_out(ext_out), .ovf(ovf), .unf(unf));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    // ==========================================================
    // Tasks
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #5;
    endtask
    task automatic mv(input logic up, input int n);
        u_enc.step(up, n);
        tick(8);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // Sequence
    initial begin
        for (int c = 0; c < 2; c++) begin
            cfg[c] = '0;
            cfg[c].method = HSQC_M_2P4;
            cfg[c].upper = UPPER_RST;
            cfg[c].lower = LOWER_RST;
        end
        tick(4);
        nrst = 1'b1;
        tick(1);
        chk(count[0], 32'h0);
        sw_en = 2'h1;
        mv(1'b1, 3);
        chk(count[0], 32'h0000_000C);
        mv(1'b0, 1);
        chk(count[0], 32'h0000_0008);
        chk(count[1], 32'h0);
        for (int i = 0; i < 2; i++) begin
            cfg[0].method = ms[i];
            mv(1'b1, 2);
            mv(1'b0, 1);
            chk(count[0], 32'h0000_0009 + i);
        end
        cap_in = 1'b1;
        tick(8);
        chk(cap_val[0], 32'h0000_000A);
        mv(1'b1, 1);
        cap_in = 1'b0;
        tick(8);
        chk(cap_val[0], 32'h0000_000B);
        cfg[0].preset = 32'h0000_0064;
        sw_preset = 2'h1;
        tick(1);
        sw_preset = 2'h0;
        tick(1);
        chk(count[0], 32'h0000_0064);
        sw_reset = 2'h1;
        tick(1);
        sw_reset = 2'h0;
        tick(1);
        chk(count[0], 32'h0);
        cfg[0].method = HSQC_M_2P4;
        cfg[0].upper = 32'h0000_0002;
        cfg[0].ovf_en = 1'b1;
        mv(1'b1, 1);
        chk(count[0], 32'h0000_0002);
        chk(ovf[0], 32'h1);
        flag_clr = 2'h1;
        tick(1);
        flag_clr = 2'h0;
        tick(1);
        chk(ovf[0], 32'h0);
        cfg[0].ring = 1'b1;
        cfg[0].lower = 32'hFFFF_FFFE;
        mv(1'b1, 1);
        chk(count[0], 32'h0000_0001);
        cfg[0].cmp_en = 16'h0001;
        cfg[0].band_act = 16'h0001;
        tick(3);
        chk(flags[0], 32'h0000_0001);
        cfg[0].cmp_en = 16'h0000;
        tick(2);
        cfg[0].ext_en = 2'h1;
        cfg[0].hold_ms = 10'h001;
        cfg[0].cmp_en = 16'h0001;
        tick(2);
        chk(ext_out[0], 32'h1);
        cfg[0].cmp_en = 16'h0000;
        tick(2);
        chk(ext_out[0], 32'h1);
        // One millisecond tick is 2000 clocks here, so the hold must be gone by now.
        tick(2100);
        chk(ext_out[0], 32'h0);
        cfg[0].ring = 1'b0;
        cfg[0].upper = UPPER_RST;
        cfg[0].src = 3'h1;
        sw_reset = 2'h1;
        tick(1);
        sw_reset = 2'h0;
        tick(12);
        chk(count[0], 32'h0000_0002);
        cfg[0].src = 3'h0;
        tbl.kind = HSQC_T_TGT;
        tbl.data = 32'h0000_0003;
        tbl.we = 1'b1;
        cfg[0].cmp_target = 1'b1;
        cfg[0].cmp_en = 16'h0001;
        cfg[0].up_act = 16'h0001;
        tick(1);
        tbl.we = 1'b0;
        mv(1'b1, 1);
        chk(flags[0], 32'h0000_0001);
        chk(ext_out[0], 32'h1);
        mv(1'b0, 1);
        chk(flags[0], 32'h0000_0000);
        cfg[0].lower = 32'h0000_0001;
        mv(1'b0, 1);
        chk(count[0], 32'h0000_0001);
        chk(unf[0], 32'h1);
        tally_and_finish();
    end
endmodule
